// ===== rtl/capture_slice_pkg.sv
// constants for the state capture memory slice
// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// [RULE_01] capture 16 data bits plus two probe qualifier bits on probe clock
// [RULE_02] timing trigger and rear panel input join qualifier bits as group five
// [RULE_03] capture registers feed comparisons only while setup load is inactive
// [RULE_04] setup load enable low blocks captured data from the comparison lookups
// [RULE_05] each qualifier match needs every group, probe bits included, to match
// [RULE_06] period qualified when either qualifier pattern matches; only then written
// [RULE_07] all don't-care patterns make every period qualify
// [RULE_08] trigger compares only the pattern chosen by the current stack level
// [RULE_09] asserted qualify input emits write pulse and delayed write pulse
// [RULE_10] control side holds qualify input true in slots one and two
// [RULE_11] slot three drives master write pulses to the address counter
// [RULE_12] slots one and two overwrite one address until a qualified period
// [RULE_13] per-slot collect inhibit stops writes; control raises all three together
// [RULE_14] processor joins three 16-bit words from one address into 48 bits
// [RULE_15] slot group select high in slot three, low in slots one and two
// [RULE_16] slot one gets inverted address bit eleven; one slot accessed at once
// [RULE_17] two byte registers feed 16 probe lines, driven only with drive enable
// [RULE_18] 20 setup bits reach the lookups only while setup load is enabled
// [RULE_19] stack level read enable puts trigger stack level on the data bus
// [RULE_20] collection address latched on capture address strobe for the write; hold_addr loads on every probe clock instead
// [RULE_21] captured word reloaded into holding register, written while strobe low
// [RULE_22] collected data read one byte at a time by low and high enables
// [RULE_23] qualifier location bits: arm, first qualifier, second qualifier, restart
// [RULE_24] data group miss blocks collection; probe group miss blocks trigger too
// [RULE_25] stack level selects one of 16 blocks of 16 trigger locations
// [RULE_26] collect inhibit holds the write pulse flop reset
// [RULE_27] comparisons are per-nibble lookups ANDed together
// [RULE_28] write happens one probe clock after capture via holding registers
package capture_slice_pkg;
	localparam int DATA_W = 16;
	localparam int QGRP_W = 4;
	localparam int GROUPS = 5;
	localparam int SETUP_W = 20;
	localparam int LEVEL_W = 4;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 10;
	localparam int PROBE_GRP = 4;
	// bit positions inside a qualifier lookup location
	localparam int BIT_ARM = 0;
	localparam int BIT_QUAL_ONE = 1;
	localparam int BIT_QUAL_TWO = 2;
	localparam int BIT_RESTART = 3;
	// reset values
	localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
	localparam logic [BYTE_W-LEVEL_W-1:0] LEVEL_PAD = 4'h0;
endpackage : capture_slice_pkg

// ===== rtl/state_capture_slice.sv
// one slot of the state acquisition path: capture, compare, collect, read back
`timescale 1ns/1ps
module state_capture_slice #(
	parameter int ADDR_W = capture_slice_pkg::ADDR_W
) (
	input wire logic SYS_CLK,
	input wire logic CLK_EN,
	input wire logic NRST,
	input wire logic PROBE_CLK,
	input wire logic [15:0] PROBE_DATA,
	input wire logic PROBE_QUAL_BIT_ONE,
	input wire logic PROBE_QUAL_BIT_TWO,
	input wire logic TIMING_TRIGGER_IN,
	input wire logic REAR_PANEL_QUALIFIER_IN,
	input wire logic PERIOD_QUALIFY_IN_N,
	input wire logic COLLECT_INHIBIT,
	input wire logic SLOT_GROUP_SELECT,
	input wire logic [3:0] TRIGGER_STACK_LEVEL,
	input wire logic [ADDR_W-1:0] COLLECTION_ADDRESS,
	input wire logic SETUP_LOAD_EN_N,
	input wire logic [19:0] SETUP_DATA,
	input wire logic [4:0] SETUP_GROUP_SEL,
	input wire logic [3:0] SETUP_BIT_SEL,
	input wire logic [3:0] SETUP_BIT_DATA,
	input wire logic SETUP_QUAL_WRITE,
	input wire logic SETUP_TRIGGER_LEVEL_MATCH_WRITE,
	input wire logic [7:0] DATA_IN,
	input wire logic PROBE_LOW_STROBE,
	input wire logic PROBE_HIGH_STROBE,
	input wire logic PROBE_DRIVE_ENABLE,
	input wire logic STACK_LEVEL_READ_EN_N,
	input wire logic LOW_BYTE_READ_EN_N,
	input wire logic HIGH_BYTE_READ_EN_N,
	input wire logic [ADDR_W-1:0] READ_ADDR,
	output logic FIRST_QUALIFIER_MATCH,
	output logic SECOND_QUALIFIER_MATCH,
	output logic ARM_MATCH,
	output logic RESTART_MATCH,
	output logic TRIGGER_LEVEL_MATCH,
	output logic WRITE_PULSE,
	output logic DELAYED_WRITE_PULSE,
	output logic CAPTURE_ADDRESS_STROBE,
	output logic WRITE_OR_READALL_STROBE_N,
	output logic MASTER_WRITE_PULSE_AT_CONTROL,
	output logic MASTER_DELAYED_PULSE_AT_CONTROL,
	output logic [15:0] PROBE_OUT,
	output logic PROBE_OE,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE
);
	localparam int DW = capture_slice_pkg::DATA_W;
	localparam int NG = capture_slice_pkg::GROUPS;
	localparam int GW = capture_slice_pkg::QGRP_W;
	localparam int LW = capture_slice_pkg::LEVEL_W;
	localparam int BW = capture_slice_pkg::BYTE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int TDEPTH = 1 << (LW + GW);

	// ----------------------------------------------------------------------
	// state records
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [LW-1:0] lvl_m;
		logic [LW-1:0] lvl_s;
		logic drv_m;
		logic drv_s;
		logic [NG-1:0][15:0][GW-1:0] qram;
		logic [NG-1:0][TDEPTH-1:0] tram;
		logic [DW-1:0] probe_out;
		logic probe_oe;
		logic [BW-1:0] data_out;
		logic data_oe;
	} sys_s;

	typedef struct packed {
		logic setup_m;
		logic setup_s;
		logic inh_m;
		logic inh_s;
		logic slot_m;
		logic slot_s;
		logic [LW-1:0] lvl_m;
		logic [LW-1:0] lvl_s;
		logic [DW-1:0] cap_word;
		logic [GW-1:0] cap_qual;
		logic qual_one;
		logic qual_two;
		logic arm;
		logic restart;
		logic trigger_level_match;
		logic [DW-1:0] hold_word;
		logic [ADDR_W-1:0] hold_addr;
		logic we;
		logic dly_we;
		logic master_we;
		logic master_dly;
		logic [DEPTH-1:0][DW-1:0] cmem;
	} probe_s;

	sys_s sy_q;
	sys_s sy_d;
	probe_s pr_q;
	probe_s pr_d;

	// ----------------------------------------------------------------------
	// reset release, one synchroniser per domain
	// ----------------------------------------------------------------------
	logic [1:0] srst_q;
	logic [1:0] prst_q;
	logic srst_n;
	logic prst_n;

	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
			srst_q <= 2'h0;
		else
			srst_q <= {srst_q[0], 1'b1};
	end

	always_ff @(posedge PROBE_CLK or negedge NRST)
	begin
		if (!NRST)
			prst_q <= 2'h0;
		else
			prst_q <= {prst_q[0], 1'b1};
	end

	assign srst_n = srst_q[1];
	assign prst_n = prst_q[1];

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	// nibble g of the 20-bit compare word; group 4 is the probe qualifier group
	function automatic logic [GW-1:0] grp_nib(input logic [DW-1:0] w,
		input logic [GW-1:0] q, input int g);
		logic [DW+GW-1:0] all;
		all = {q, w};
		grp_nib = all[g*GW +: GW];
	endfunction : grp_nib

	// ----------------------------------------------------------------------
	// processor side: setup lookups, probe output, read back
	// ----------------------------------------------------------------------
	always_comb
	begin
		sy_d = sy_q;
		sy_d.lvl_m = TRIGGER_STACK_LEVEL;
		sy_d.lvl_s = sy_q.lvl_m;
		sy_d.drv_m = PROBE_DRIVE_ENABLE;
		sy_d.drv_s = sy_q.drv_m;
		// setup data only reaches the lookups while the load enable is low
		if (!SETUP_LOAD_EN_N) // RULE_18
		begin
			for (int g = 0; g < NG; g++)
			begin
				if (SETUP_GROUP_SEL[g] && SETUP_QUAL_WRITE)
				begin
					for (int b = 0; b < GW; b++)
					begin
						if (SETUP_BIT_SEL[b])
							sy_d.qram[g][SETUP_DATA[g*GW +: GW]][b] = SETUP_BIT_DATA[b]; // RULE_23
					end
				end
				if (SETUP_GROUP_SEL[g] && SETUP_TRIGGER_LEVEL_MATCH_WRITE)
					sy_d.tram[g][{sy_q.lvl_s, SETUP_DATA[g*GW +: GW]}] = SETUP_BIT_DATA[0]; // RULE_25
			end
		end
		if (PROBE_LOW_STROBE) // RULE_17
			sy_d.probe_out[BW-1:0] = DATA_IN;
		if (PROBE_HIGH_STROBE) // RULE_17
			sy_d.probe_out[DW-1:BW] = DATA_IN;
		sy_d.probe_oe = sy_q.drv_s; // RULE_17
		// stack level read wins over a collected byte if both are enabled
		sy_d.data_oe = !STACK_LEVEL_READ_EN_N || !LOW_BYTE_READ_EN_N || !HIGH_BYTE_READ_EN_N;
		if (!STACK_LEVEL_READ_EN_N) // RULE_19
			sy_d.data_out = {capture_slice_pkg::LEVEL_PAD, sy_q.lvl_s};
		else if (!LOW_BYTE_READ_EN_N) // RULE_22
			sy_d.data_out = pr_q.cmem[READ_ADDR][BW-1:0];
		else if (!HIGH_BYTE_READ_EN_N) // RULE_22
			sy_d.data_out = pr_q.cmem[READ_ADDR][DW-1:BW];
		else
			sy_d.data_out = capture_slice_pkg::BYTE_RST;
	end

	always_ff @(posedge SYS_CLK or negedge srst_n)
	begin
		if (!srst_n)
			sy_q <= '0;
		else if (CLK_EN)
			sy_q <= sy_d;
	end

	// ----------------------------------------------------------------------
	// probe clock side: capture, compare, write pulses, collection memory
	// ----------------------------------------------------------------------
	logic [GW-1:0] q_and;
	logic t_and;
	logic probe_qual;

	always_comb
	begin
		q_and = '1;
		t_and = 1'b1;
		for (int g = 0; g < NG; g++)
		begin
			// per-nibble lookups combined by AND; don't-cares stored as matches
			q_and = q_and & sy_q.qram[g][grp_nib(pr_q.cap_word, pr_q.cap_qual, g)]; // RULE_27
			t_and = t_and & sy_q.tram[g][{pr_q.lvl_s,
				grp_nib(pr_q.cap_word, pr_q.cap_qual, g)}]; // RULE_08
		end
	end

	// a trigger also needs the probe group to match either qualifier pattern
	assign probe_qual = sy_q.qram[capture_slice_pkg::PROBE_GRP][pr_q.cap_qual][capture_slice_pkg::BIT_QUAL_ONE]
		|| sy_q.qram[capture_slice_pkg::PROBE_GRP][pr_q.cap_qual][capture_slice_pkg::BIT_QUAL_TWO];

	always_comb
	begin
		pr_d = pr_q;
		pr_d.setup_m = !SETUP_LOAD_EN_N;
		pr_d.setup_s = pr_q.setup_m;
		pr_d.inh_m = COLLECT_INHIBIT;
		pr_d.inh_s = pr_q.inh_m;
		pr_d.slot_m = SLOT_GROUP_SELECT; // RULE_15
		pr_d.slot_s = pr_q.slot_m;
		pr_d.lvl_m = TRIGGER_STACK_LEVEL;
		pr_d.lvl_s = pr_q.lvl_m;
		pr_d.cap_word = PROBE_DATA; // RULE_01
		pr_d.cap_qual = {REAR_PANEL_QUALIFIER_IN, TIMING_TRIGGER_IN,
			PROBE_QUAL_BIT_TWO, PROBE_QUAL_BIT_ONE}; // RULE_02
		// matches are forced false while setup owns the lookups
		pr_d.qual_one = !pr_q.setup_s && q_and[capture_slice_pkg::BIT_QUAL_ONE]; // RULE_03 RULE_05
		pr_d.qual_two = !pr_q.setup_s && q_and[capture_slice_pkg::BIT_QUAL_TWO]; // RULE_04 RULE_05
		pr_d.arm = !pr_q.setup_s && q_and[capture_slice_pkg::BIT_ARM];
		pr_d.restart = !pr_q.setup_s && q_and[capture_slice_pkg::BIT_RESTART];
		pr_d.trigger_level_match = !pr_q.setup_s && t_and && probe_qual; // RULE_24
		// holding registers decouple the write from the next capture
		pr_d.hold_word = pr_q.cap_word; // RULE_21 RULE_28
		pr_d.hold_addr = COLLECTION_ADDRESS; // RULE_20
		// qualify input comes back from control; for slot three it carries data_qual
		pr_d.we = !PERIOD_QUALIFY_IN_N && !pr_q.setup_s; // RULE_06 RULE_07 RULE_09 RULE_12
		pr_d.dly_we = pr_q.we; // RULE_09
		if (pr_q.inh_s) // RULE_13 RULE_26
		begin
			pr_d.we = 1'b0;
			pr_d.dly_we = 1'b0;
		end
		pr_d.master_we = pr_d.we && pr_q.slot_s; // RULE_11
		pr_d.master_dly = pr_d.dly_we && pr_q.slot_s; // RULE_11
		if (pr_q.we) // RULE_20 RULE_21
			pr_d.cmem[pr_q.hold_addr] = pr_q.hold_word;
	end

	always_ff @(posedge PROBE_CLK or negedge prst_n)
	begin
		if (!prst_n)
			pr_q <= '0;
		else
			pr_q <= pr_d;
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign FIRST_QUALIFIER_MATCH = pr_q.qual_one;
	assign SECOND_QUALIFIER_MATCH = pr_q.qual_two;
	assign ARM_MATCH = pr_q.arm;
	assign RESTART_MATCH = pr_q.restart;
	assign TRIGGER_LEVEL_MATCH = pr_q.trigger_level_match;
	assign WRITE_PULSE = pr_q.we;
	assign DELAYED_WRITE_PULSE = pr_q.dly_we;
	assign CAPTURE_ADDRESS_STROBE = pr_q.we;
	assign WRITE_OR_READALL_STROBE_N = !pr_q.we;
	assign MASTER_WRITE_PULSE_AT_CONTROL = pr_q.master_we;
	assign MASTER_DELAYED_PULSE_AT_CONTROL = pr_q.master_dly;
	assign PROBE_OUT = sy_q.probe_out;
	assign PROBE_OE = sy_q.probe_oe;
	assign DATA_OUT = sy_q.data_out;
	assign DATA_OE = sy_q.data_oe;

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	chk_write_cause: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_09
		pr_q.we |-> $past(!PERIOD_QUALIFY_IN_N && !pr_q.inh_s && !pr_q.setup_s))
		else $error("write pulse without qualify input");
	chk_inhibit_stops_writes: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_26
		pr_q.inh_s |=> !pr_q.we && !pr_q.dly_we)
		else $error("write pulse while inhibited");
	chk_delayed_follows: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_09
		pr_q.we && !pr_q.inh_s |=> pr_q.dly_we)
		else $error("delayed write pulse missing");
	chk_memory_write: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_21
		pr_q.we |=> pr_q.cmem[$past(pr_q.hold_addr)] == $past(pr_q.hold_word))
		else $error("collection memory not written");
	chk_hold_word_delay: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_28
		1'b1 |=> ##1 pr_q.hold_word == $past(PROBE_DATA, 2))
		else $error("holding word not one clock behind capture");
	chk_setup_blocks: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_04
		pr_q.setup_s |=> !pr_q.qual_one && !pr_q.qual_two && !pr_q.trigger_level_match && !pr_q.we)
		else $error("match or write during setup load");
	chk_master_slot: assert property (@(posedge PROBE_CLK) disable iff (!prst_n) // RULE_11
		pr_q.we && !pr_q.slot_m |-> !pr_q.master_we || $past(pr_q.slot_s))
		else $error("master pulse from a low slot");
	chk_stack_read: assert property (@(posedge SYS_CLK) disable iff (!srst_n) // RULE_19
		CLK_EN && !STACK_LEVEL_READ_EN_N |=> sy_q.data_oe
			&& sy_q.data_out[LW-1:0] == $past(sy_q.lvl_s))
		else $error("stack level not on data bus");
	chk_probe_low_load: assert property (@(posedge SYS_CLK) disable iff (!srst_n) // RULE_17
		CLK_EN && PROBE_LOW_STROBE |=> sy_q.probe_out[BW-1:0] == $past(DATA_IN))
		else $error("probe low byte not loaded");
	chk_probe_drive: assert property (@(posedge SYS_CLK) disable iff (!srst_n) // RULE_17
		CLK_EN && !sy_q.drv_s |=> !sy_q.probe_oe)
		else $error("probe lines driven without enable");

	cov_write: cover property (@(posedge PROBE_CLK) disable iff (!prst_n)
		pr_q.we ##1 pr_q.dly_we);
	cov_trigger: cover property (@(posedge PROBE_CLK) disable iff (!prst_n) pr_q.trigger_level_match);
	cov_master: cover property (@(posedge PROBE_CLK) disable iff (!prst_n) pr_q.master_we);
	cov_byte_read: cover property (@(posedge SYS_CLK) disable iff (!srst_n)
		CLK_EN && !HIGH_BYTE_READ_EN_N ##1 sy_q.data_oe);
endmodule : state_capture_slice

// ===== testbench/probe_side_model.sv
// probe pod and control board stand-in facing the capture slice
`timescale 1ns/1ps
module probe_side_model (
	input wire logic probe_clk,
	input wire logic nrst,
	input wire logic [19:0] req_word,
	input wire logic req_qual_n,
	input wire logic master_delayed,
	output logic [19:0] word,
	output logic qual_n,
	output logic [9:0] addr
);
	logic qual_d;
	// ------------------------------
	// pod word and address counter
	// ------------------------------
	// outputs move 1 ns after the edge so the slice samples settled values
	always @(posedge probe_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			word <= 20'h00000;
			qual_d <= 1'h1;
			qual_n <= 1'h1;
			addr <= 10'h000;
		end
		else
		begin
			word <= #1 req_word;
			// qualify lags its word by one period, as the comparison result does
			qual_d <= req_qual_n;
			qual_n <= #1 qual_d;
			if (master_delayed === 1'h1)
			begin
				addr <= #1 addr + 10'h001;
			end
		end
	end
endmodule : probe_side_model

// ===== testbench/state_capture_memory_slice_bench.sv
// self-checking bench for the state capture slice
`timescale 1ns/1ps
module state_capture_memory_slice_bench;
	logic sys_clk, probe_clk, nrst, inh, setup_n, qwr, twr, lo_stb, hi_stb, pden, req_qual_n;
	logic qual_n, q1, q2, trg, wp, dwp, wrs_n, mwp, mdp, poe, doe, cas;
	logic [15:0] ac = 16'h0000;
	logic [19:0] req_word, word, sdata;
	logic [9:0] addr, raddr;
	logic [4:0] sgrp;
	logic [3:0] sbit, lvl;
	logic [7:0] din, dout;
	logic [15:0] pout;
	logic [2:0] ren_n;
	logic [15:0] wc = 16'h0000;
	logic [15:0] dc = 16'h0000;
	logic [15:0] mc = 16'h0000;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [19:0] mw [5] = '{20'h06666, 20'hF7777, 20'hFAAAA, 20'hFAAAA, 20'h0AAAA};
	logic [3:0] ml [5] = '{4'h3, 4'h3, 4'h3, 4'h5, 4'h3};
	logic [2:0] me [5] = '{3'h4, 3'h2, 3'h3, 3'h2, 3'h1};
	logic [15:0] cwd [3] = '{16'h3A51, 16'hC46E, 16'h0FF0};

	state_capture_slice #(.ADDR_W(10)) state_capture_slice_inst (
		.SYS_CLK(sys_clk), .CLK_EN(1'h1), .NRST(nrst), .PROBE_CLK(probe_clk),
		.PROBE_DATA(word[15:0]), .PROBE_QUAL_BIT_ONE(word[16]), .PROBE_QUAL_BIT_TWO(word[17]),
		.TIMING_TRIGGER_IN(word[18]), .REAR_PANEL_QUALIFIER_IN(word[19]),
		.PERIOD_QUALIFY_IN_N(qual_n), .COLLECT_INHIBIT(inh), .SLOT_GROUP_SELECT(1'h1),
		.TRIGGER_STACK_LEVEL(lvl), .COLLECTION_ADDRESS(addr), .SETUP_LOAD_EN_N(setup_n),
		.SETUP_DATA(sdata), .SETUP_GROUP_SEL(sgrp), .SETUP_BIT_SEL(sbit),
		.SETUP_BIT_DATA(4'hF), .SETUP_QUAL_WRITE(qwr), .SETUP_TRIGGER_LEVEL_MATCH_WRITE(twr), .DATA_IN(din),
		.PROBE_LOW_STROBE(lo_stb), .PROBE_HIGH_STROBE(hi_stb), .PROBE_DRIVE_ENABLE(pden),
		.STACK_LEVEL_READ_EN_N(ren_n[2]), .LOW_BYTE_READ_EN_N(ren_n[1]),
		.HIGH_BYTE_READ_EN_N(ren_n[0]), .READ_ADDR(raddr),
		.FIRST_QUALIFIER_MATCH(q1), .SECOND_QUALIFIER_MATCH(q2), .ARM_MATCH(), .RESTART_MATCH(),
		.TRIGGER_LEVEL_MATCH(trg), .WRITE_PULSE(wp), .DELAYED_WRITE_PULSE(dwp),
		.CAPTURE_ADDRESS_STROBE(cas), .WRITE_OR_READALL_STROBE_N(wrs_n),
		.MASTER_WRITE_PULSE_AT_CONTROL(mwp), .MASTER_DELAYED_PULSE_AT_CONTROL(mdp),
		.PROBE_OUT(pout), .PROBE_OE(poe), .DATA_OUT(dout), .DATA_OE(doe)
	);

	probe_side_model probe_side_model_inst (
		.probe_clk(probe_clk), .nrst(nrst), .req_word(req_word), .req_qual_n(req_qual_n),
		.master_delayed(mdp), .word(word), .qual_n(qual_n), .addr(addr)
	);

	// ----------------------------
	// clocks, timeout, pulse counts
	// ----------------------------
	initial
	begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// probe clock offset so its edges never line up with the system clock
	initial
	begin
		probe_clk = 1'h0;
		#1.7;
		forever #3 probe_clk = ~probe_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			results();
		end
	end
	always @(posedge probe_clk)
	begin
		if (wp === 1'h1)
			wc++;
		if (dwp === 1'h1)
			dc++;
		if (mwp === 1'h1)
			mc++;
		if (cas === 1'h1)
			ac++;
	end

	// ----------------------------
	// tasks
	// ----------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic sw(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : sw

	task automatic pw(input int n);
		repeat (n) @(posedge probe_clk);
		#1;
	endtask : pw

	// the model picks up the request at the following probe edge
	task automatic send(input logic [19:0] w, input logic qn);
		@(posedge probe_clk);
		#2;
		req_word = w;
		req_qual_n = qn;
	endtask : send

	task automatic su(input logic [4:0] g, input logic [3:0] b, input logic [3:0] a, input logic t);
		sw(1);
		sgrp = g;
		sbit = b;
		sdata = {5{a}};
		qwr = ~t;
		twr = t;
		sw(1);
		qwr = 1'h0;
		twr = 1'h0;
	endtask : su

	task automatic rd(input logic [2:0] en, input logic [9:0] a, input logic [7:0] exp);
		sw(1);
		ren_n = en;
		raddr = a;
		sw(2);
		chk(doe, 1'h1);
		chk(dout, exp);
		ren_n = 3'h7;
		sw(1);
	endtask : rd

	task automatic results;
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ----------------------------
	// main sequence
	// ----------------------------
	initial
	begin
		{nrst, inh, qwr, twr, lo_stb, hi_stb, pden} = 7'h00;
		{setup_n, req_qual_n, ren_n} = 5'h1F;
		{req_word, sdata, sgrp, sbit, din, raddr} = 57'h0;
		lvl = 4'h3;
		repeat (4) @(posedge sys_clk);
		chk(wrs_n, 1'h1);
		#1 nrst = 1'h1;
		sw(4);
		setup_n = 1'h0;
		sw(4);
		for (int a = 0; a < 16; a++)
		begin
			su(5'h1E, 4'h2, a[3:0], 1'h0);
			su(5'h0F, 4'h4, a[3:0], 1'h0);
			su(5'h1E, 4'h1, a[3:0], 1'h1);
		end
		su(5'h01, 4'h2, 4'h6, 1'h0);
		su(5'h10, 4'h4, 4'hF, 1'h0);
		su(5'h01, 4'h1, 4'hA, 1'h1);
		send(20'h06666, 1'h0);
		send(20'h06666, 1'h1);
		pw(6);
		chk(q1, 1'h0);
		chk(wc, 16'h0000);
		sw(1);
		setup_n = 1'h1;
		sw(4);
		for (int i = 0; i < 5; i++)
		begin
			sw(1);
			lvl = ml[i];
			send(mw[i], 1'h1);
			pw(8);
			chk({13'h0000, q1, q2, trg}, {13'h0000, me[i]});
		end
		for (int k = 0; k < 3; k++)
		begin
			send({4'h0, cwd[k]}, 1'h0);
			send({4'h0, cwd[k]}, 1'h1);
			pw(6);
		end
		send(20'h01234, 1'h1);
		pw(6);
		chk(wc, 16'h0003);
		chk(dc, 16'h0003);
		chk(mc, 16'h0003);
		chk(ac, 16'h0003);
		sw(1);
		inh = 1'h1;
		pw(4);
		send(20'h05555, 1'h0);
		send(20'h05555, 1'h1);
		pw(6);
		chk(wc, 16'h0003);
		chk(addr, 16'h0003);
		for (int k = 0; k < 3; k++)
		begin
			rd(3'h5, k[9:0], cwd[k][7:0]);
			rd(3'h6, k[9:0], cwd[k][15:8]);
		end
		rd(3'h5, 10'h003, 8'h00);
		rd(3'h3, 10'h000, 8'h03);
		din = 8'h5A;
		lo_stb = 1'h1;
		sw(1);
		lo_stb = 1'h0;
		din = 8'hC3;
		hi_stb = 1'h1;
		sw(1);
		hi_stb = 1'h0;
		pden = 1'h1;
		sw(5);
		chk(pout, 16'hC35A);
		chk(poe, 1'h1);
		pden = 1'h0;
		sw(5);
		chk(poe, 1'h0);
		results();
	end
endmodule : state_capture_memory_slice_bench
